// ### design/uarx_pkg.sv
// Types shared by the asynchronous receiver
package uarx_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_BITS = 2'h3,
    ST_STOP = 2'h2
  } uarx_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic dor;
    logic upe;
  } uarx_entry_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    uarx_state_e st;
    logic [4:0] cnt;
    logic [1:0] votes;
    logic [3:0] bidx;
    logic [8:0] sh;
    logic pbit;
    logic pen_l;
    logic podd_l;
    logic hold_v;
    uarx_entry_s hold;
    logic dor_pend;
    uarx_entry_s [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] level;
    logic rx_en;
    logic rxc_ie;
    logic size2;
    logic dbl;
    logic [1:0] size_lo;
    logic stop2;
    logic podd;
    logic pen;
    logic [31:0] prdata;
  } uarx_state_s;
endpackage : uarx_pkg

// ### design/uarx_receiver.sv
// Asynchronous serial receiver with two-entry buffer and APB registers
// Notes on behaviour
// - Receive-complete flag is one exactly while an unread character is buffered.
// - Clearing receiver enable empties the buffer, dropping the complete flag.
// - Interrupt request holds while flag, its enable and global enable are set.
// - Error flags buffered with character; data read advances to next entry.
// - Status writes never alter frame, overrun or parity error flags.
// - Error flags never raise an interrupt request on their own.
// - Frame error follows only the first stop bit; later stops ignored.
// - Overrun set when buffer full, character waiting and new start seen.
// - Overrun indication clears on the next successful transfer into buffer.
// - With parity checking off, parity error reads zero.
// - Upper parity bit enables checking, lower selects odd or even.
// - Parity error kept only if checking was on at arrival.
// - Disable is immediate: abort reception, drop buffer, release pin.
// - Sample at sixteen times baud, or eight in double speed.
// - Start bit voted on samples 8-10 or 4-6; high majority rejects.
// - After rejection search again; resynchronise on every start bit.
// - Per-bit sequence of sixteen or eight states, sample equals state.
// - Every bit decided by majority of the three centre samples.
// - Zero first stop bit sets the frame error for that character.
// - Next start edge can be seen right after the last stop vote.
// - Setting receiver enable takes over the receive pin.
// - Ninth bit buffered with character and shown in a control bit.
// - Unused upper data bits read as zero for short characters.
`timescale 1ns/1ns
`include "uarx_regs.svh"
module uarx_receiver (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial line and baud tick
  input wire logic i_serial_rx_pin,
  input wire logic i_baud_tick,
  // System side
  input wire logic i_global_irq_en,
  output logic o_rx_irq,
  output logic o_rx_pin_override
);
  uarx_pkg::uarx_state_s s_q;
  uarx_pkg::uarx_state_s s_d;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    case (sz)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      3'h7: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction : data_bits

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `UARX_OFS_DATA) || (a == `UARX_OFS_STAT) ||
              (a == `UARX_OFS_CTLB) || (a == `UARX_OFS_CTLC);
  endfunction : addr_ok

  uarx_pkg::uarx_entry_s head;
  logic have;
  logic setup;
  logic acc_wr;
  logic acc_rd;

  assign have = (s_q.level != 2'h0);
  assign head = have ? s_q.fifo[s_q.rp] : '0;
  assign setup = i_psel & ~i_penable;
  assign acc_wr = i_psel & i_penable & i_pwrite;
  assign acc_rd = i_psel & i_penable & ~i_pwrite;

  always_comb begin
    logic smp;
    logic b;
    logic pop;
    logic push;
    logic [4:0] spb;
    logic [4:0] vlo;
    logic [4:0] vhi;
    logic [3:0] nb;
    logic [3:0] nt;
    logic [1:0] lvl;
    uarx_pkg::uarx_entry_s ent;
    s_d = s_q;
    smp = s_q.sync2;
    b = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    ent = '0;
    spb = s_q.dbl ? `UARX_SPB_DBL : `UARX_SPB_NORM;
    vlo = s_q.dbl ? `UARX_VLO_DBL : `UARX_VLO_NORM;
    vhi = s_q.dbl ? `UARX_VHI_DBL : `UARX_VHI_NORM;
    nb = data_bits({s_q.size2, s_q.size_lo});
    nt = nb + {3'h0, s_q.pen_l};
    lvl = s_q.level;
    // Line synchroniser
    s_d.sync1 = i_serial_rx_pin;
    s_d.sync2 = s_q.sync1;

    // Read of the data location pops the head entry
    if (acc_rd && i_paddr == `UARX_OFS_DATA && have) begin
      pop = 1'b1;
      s_d.rp = ~s_q.rp;
      lvl = lvl - 2'h1;
    end
    // Waiting character moves into the buffer when room exists
    if (s_q.hold_v && lvl != `UARX_DEPTH) begin
      push = 1'b1;
      s_d.fifo[s_q.wp] = s_q.hold;
      s_d.fifo[s_q.wp].dor = s_q.dor_pend;
      s_d.dor_pend = 1'b0;
      s_d.wp = ~s_q.wp;
      s_d.hold_v = 1'b0;
      lvl = lvl + 2'h1;
    end
    s_d.level = lvl;

    // Oversampled receive engine
    if (i_baud_tick && s_q.rx_en) begin
      if (s_q.st == uarx_pkg::ST_IDLE) begin
        s_d.prev = smp;
        if (s_q.prev && !smp) begin
          if (s_q.hold_v && s_q.level == `UARX_DEPTH) begin
            s_d.dor_pend = 1'b1;
          end else begin
            s_d.st = uarx_pkg::ST_START;
            // Edge tick was sample one, so the next tick is two
            s_d.cnt = 5'h02;
            s_d.pen_l = s_q.pen;
            s_d.podd_l = s_q.podd;
            s_d.sh = '0;
          end
        end
      end else begin
        s_d.cnt = (s_q.cnt == spb) ? 5'h01 : s_q.cnt + 5'h01;
        if (s_q.cnt >= vlo && s_q.cnt < vhi) begin
          s_d.votes = {s_q.votes[0], smp};
        end
        if (s_q.cnt == vhi) begin
          b = maj3({s_q.votes, smp});
          case (s_q.st)
            uarx_pkg::ST_START: begin
              if (b) begin
                s_d.st = uarx_pkg::ST_IDLE;
                s_d.prev = smp;
              end else begin
                s_d.st = uarx_pkg::ST_BITS;
                s_d.bidx = 4'h0;
              end
            end
            uarx_pkg::ST_BITS: begin
              if (s_q.bidx < nb) begin
                s_d.sh[s_q.bidx] = b;
              end else begin
                s_d.pbit = b;
              end
              s_d.bidx = s_q.bidx + 4'h1;
              if (s_q.bidx + 4'h1 == nt) begin
                s_d.st = uarx_pkg::ST_STOP;
              end
            end
            uarx_pkg::ST_STOP: begin
              ent.data = s_q.sh;
              ent.fe = ~b;
              ent.upe = s_q.pen_l &
                (^s_q.sh ^ s_q.pbit ^ s_q.podd_l);
              ent.dor = 1'b0;
              s_d.hold = ent;
              s_d.hold_v = 1'b1;
              s_d.st = uarx_pkg::ST_IDLE;
              s_d.prev = smp;
            end
            default: s_d.st = uarx_pkg::ST_IDLE;
          endcase
        end
      end
    end

    // Register writes; error flags are not writable
    if (acc_wr) begin
      case (i_paddr)
        `UARX_OFS_STAT: s_d.dbl = i_pwdata[`UARX_A_DBL];
        `UARX_OFS_CTLB: begin
          s_d.rx_en = i_pwdata[`UARX_B_RXEN];
          s_d.rxc_ie = i_pwdata[`UARX_B_RXCIE];
          s_d.size2 = i_pwdata[`UARX_B_SIZE2];
        end
        `UARX_OFS_CTLC: begin
          s_d.size_lo = i_pwdata[`UARX_C_SIZE_LO +: 2];
          s_d.stop2 = i_pwdata[`UARX_C_STOP2];
          s_d.podd = i_pwdata[`UARX_C_PODD];
          s_d.pen = i_pwdata[`UARX_C_PEN];
        end
        default: s_d.prdata = s_q.prdata;
      endcase
    end

    // Read data captured in the setup cycle
    if (setup && !i_pwrite) begin
      s_d.prdata = '0;
      case (i_paddr)
        `UARX_OFS_DATA: s_d.prdata[7:0] = head.data[7:0];
        `UARX_OFS_STAT: begin
          s_d.prdata[`UARX_A_RXC] = have;
          s_d.prdata[`UARX_A_FE] = head.fe;
          s_d.prdata[`UARX_A_DOR] = head.dor;
          s_d.prdata[`UARX_A_UPE] = head.upe;
          s_d.prdata[`UARX_A_DBL] = s_q.dbl;
        end
        `UARX_OFS_CTLB: begin
          s_d.prdata[`UARX_B_RXEN] = s_q.rx_en;
          s_d.prdata[`UARX_B_RXCIE] = s_q.rxc_ie;
          s_d.prdata[`UARX_B_RX9] = head.data[8];
          s_d.prdata[`UARX_B_SIZE2] = s_q.size2;
        end
        `UARX_OFS_CTLC: begin
          s_d.prdata[`UARX_C_SIZE_LO +: 2] = s_q.size_lo;
          s_d.prdata[`UARX_C_STOP2] = s_q.stop2;
          s_d.prdata[`UARX_C_PODD] = s_q.podd;
          s_d.prdata[`UARX_C_PEN] = s_q.pen;
        end
        default: s_d.prdata = '0;
      endcase
    end

    // Disabled receiver: abort and flush, from the disabling write on
    if (!s_d.rx_en) begin
      s_d.st = uarx_pkg::ST_IDLE;
      s_d.prev = 1'b0;
      s_d.level = 2'h0;
      s_d.wp = 1'b0;
      s_d.rp = 1'b0;
      s_d.hold_v = 1'b0;
      s_d.dor_pend = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.st <= uarx_pkg::ST_IDLE;
      {s_q.rxc_ie, s_q.rx_en} <= `UARX_RST_CTLB;
      {s_q.pen, s_q.podd, s_q.stop2, s_q.size_lo} <= `UARX_RST_CTLC;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok(i_paddr);
  // Error flags take no part in the request
  assign o_rx_irq = have & s_q.rxc_ie & i_global_irq_en;
  assign o_rx_pin_override = s_q.rx_en;
endmodule : uarx_receiver

// ### design/uarx_regs.svh
// Register map, field positions and sampling constants of the receiver
`ifndef UARX_REGS_SVH
`define UARX_REGS_SVH
// Register byte offsets
`define UARX_OFS_DATA 8'h00
`define UARX_OFS_STAT 8'h04
`define UARX_OFS_CTLB 8'h08
`define UARX_OFS_CTLC 8'h0c
// status_reg_a fields
`define UARX_A_RXC 0
`define UARX_A_FE 1
`define UARX_A_DOR 2
`define UARX_A_UPE 3
`define UARX_A_DBL 4
// control_reg_b fields
`define UARX_B_RXEN 0
`define UARX_B_RXCIE 1
`define UARX_B_RX9 2
`define UARX_B_SIZE2 3
// control_reg_c fields
`define UARX_C_SIZE_LO 0
`define UARX_C_STOP2 2
`define UARX_C_PODD 3
`define UARX_C_PEN 4
// Reset values
`define UARX_RST_CTLB 2'h0
`define UARX_RST_CTLC 5'h03
// Oversampling: samples per bit and vote windows
`define UARX_SPB_NORM 5'h10
`define UARX_SPB_DBL 5'h08
`define UARX_VLO_NORM 5'h08
`define UARX_VHI_NORM 5'h0a
`define UARX_VLO_DBL 5'h04
`define UARX_VHI_DBL 5'h06
// Buffer depth
`define UARX_DEPTH 2'h2
`endif

// ### test/uarx_monitor.sv
// Port-level checks of the receiver
`timescale 1ns/1ns
module uarx_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Line and system
  input wire logic i_serial_rx_pin,
  input wire logic i_baud_tick,
  input wire logic i_global_irq_en,
  input wire logic o_rx_irq,
  input wire logic o_rx_pin_override
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  wire logic acc = i_psel && i_penable;
  wire logic map = i_paddr[7:4] == 4'h0 && i_paddr[1:0] == 2'h0;
  wire logic pop = acc && i_paddr == (i_pwrite ? 8'h08 : 8'h00);
  sequence s_ctl_wr;
    i_psel && !i_penable && i_pwrite && i_paddr == 8'h08 ##1 acc;
  endsequence
  sequence s_irq_kept;
    o_rx_irq && !pop ##1 i_global_irq_en;
  endsequence
  AST_READY: assert property (o_pready) else $error("pready low");
  AST_SLVERR: assert property (o_pslverr == (acc && !map))
    else $error("pslverr wrong");
  AST_UPPER_ZERO: assert property (
    acc && map |-> o_prdata[31:8] == 24'h0) else $error("upper bits set");
  AST_IRQ_GLOBAL: assert property (
    !i_global_irq_en |-> !o_rx_irq) else $error("irq without global");
  AST_PIN: assert property (
    s_ctl_wr |=> o_rx_pin_override == $past(i_pwdata[0]))
    else $error("pin override wrong");
  AST_IE_OFF: assert property (
    s_ctl_wr ##0 !i_pwdata[1] |=> !o_rx_irq) else $error("irq not masked");
  AST_DISABLE: assert property (
    s_ctl_wr ##0 !i_pwdata[0] |=> !o_rx_irq [*8])
    else $error("irq after disable");
  AST_IRQ_HOLD: assert property (s_irq_kept |-> o_rx_irq)
    else $error("irq dropped");
endmodule : uarx_monitor
bind uarx_receiver uarx_monitor u_mon (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_serial_rx_pin(i_serial_rx_pin), .i_baud_tick(i_baud_tick),
  .i_global_irq_en(i_global_irq_en), .o_rx_irq(o_rx_irq),
  .o_rx_pin_override(o_rx_pin_override));

// ### test/uarx_receiver_tb.sv
// Self-checking bench for the asynchronous receiver
`timescale 1ns/1ns
module uarx_receiver_tb;
  typedef struct packed {
    logic [8:0] d;
    logic [2:0] sz;
    logic [1:0] pm;
    logic bad;
    logic stp;
    logic dbl;
    logic [7:0] xd;
    logic [3:0] xs;
  } uarx_row_s;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic gie = 1'h1;
  logic tick = 1'h0;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, ovr, line;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  uarx_row_s r;
  uarx_row_s rows [8] = '{
    '{9'h0a5, 3'h3, 2'h0, 1'h0, 1'h1, 1'h0, 8'ha5, 4'h1},
    '{9'h1ff, 3'h0, 2'h0, 1'h0, 1'h1, 1'h0, 8'h1f, 4'h1},
    '{9'h02a, 3'h1, 2'h2, 1'h0, 1'h1, 1'h0, 8'h2a, 4'h1},
    '{9'h055, 3'h2, 2'h3, 1'h1, 1'h1, 1'h0, 8'h55, 4'h9},
    '{9'h0c3, 3'h3, 2'h0, 1'h0, 1'h0, 1'h0, 8'hc3, 4'h3},
    '{9'h13c, 3'h7, 2'h0, 1'h0, 1'h1, 1'h1, 8'h3c, 4'h1},
    '{9'h0f0, 3'h3, 2'h3, 1'h0, 1'h1, 1'h1, 8'hf0, 4'h1},
    '{9'h081, 3'h3, 2'h2, 1'h1, 1'h0, 1'h0, 8'h81, 4'hb}};
  initial begin
    forever #50 clk = ~clk;
  end
  // Oversample tick every fourth clock, and the hang limit
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= tdiv == 2'h3;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end
  uarx_tx_model tx (.i_clk_sys(clk), .i_baud_tick(tick), .o_line(line));
  uarx_receiver uut (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_rx_pin(line), .i_baud_tick(tick), .i_global_irq_en(gie),
    .o_rx_irq(irq), .o_rx_pin_override(ovr));
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic rx(input uarx_row_s f);
    logic [11:0] b;
    int n, k;
    logic p;
    b = 12'h0;
    n = f.sz[2] ? 9 : f.sz + 5;
    p = f.pm[0] ^ f.bad;
    for (k = 1; k <= n; k++) begin
      b[k] = f.d[k-1];
      p ^= f.d[k-1];
    end
    if (f.pm[1]) begin
      b[k] = p;
      k++;
    end
    b[k] = f.stp;
    tx.send(b, k + 1, f.dbl ? 8 : 16);
    for (int i = 0; i < 200 && irq !== 1'h1; i++) @(posedge clk);
  endtask : rx
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    apb(1'h0, 8'h08, 32'h0);
    chk("ctlb reset", 32'h0, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("ctlc reset", 32'h3, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("pin reset", 32'h0, {31'h0, ovr});
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'h1, 8'h0c, {27'h0, r.pm, r.dbl, r.sz[1:0]});
      apb(1'h1, 8'h08, {28'h0, r.sz[2], 3'h3});
      apb(1'h1, 8'h04, {27'h0, r.dbl, 4'h0});
      rx(r);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'h0, 8'h04, 32'h0);
      chk("status", {27'h0, r.dbl, r.xs}, rd);
      apb(1'h0, 8'h08, 32'h0);
      if (r.sz[2]) chk("ninth", {31'h0, r.d[8]}, {31'h0, rd[2]});
      apb(1'h0, 8'h00, 32'h0);
      chk("data", {24'h0, r.xd}, rd);
      chk("irq empty", 32'h0, {31'h0, irq});
    end
    $display("test table done");
    r = rows[7];
    r.stp = 1'h1;
    r.bad = 1'h0;
    for (int k = 1; k < 5; k++) begin
      r.d = 9'(k);
      rx(r);
    end
    apb(1'h1, 8'h04, 32'h0000000e);
    for (int k = 1; k < 4; k++) begin
      apb(1'h0, 8'h04, 32'h0);
      chk("ovr status", {29'h0, k == 3, 2'h1}, rd);
      apb(1'h0, 8'h00, 32'h0);
      chk("ovr data", 32'(k), rd);
    end
    apb(1'h0, 8'h04, 32'h0);
    chk("flushed", 32'h0, rd);
    $display("test overrun done");
    r.d = 9'h0a5;
    tx.send(12'h0, 1, 8);
    tx.send(12'hfff, 1, 16);
    rx(r);
    apb(1'h0, 8'h04, 32'h0);
    chk("glitch status", 32'h1, rd);
    apb(1'h0, 8'h00, 32'h0);
    chk("glitch data", 32'ha5, rd);
    $display("test noise done");
    rx(r);
    gie <= 1'h0;
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    gie <= 1'h1;
    apb(1'h1, 8'h08, 32'h0);
    chk("pin released", 32'h0, {31'h0, ovr});
    apb(1'h0, 8'h04, 32'h0);
    chk("flag cleared", 32'h0, rd);
    apb(1'h1, 8'h08, 32'h3);
    r.d = 9'h0ff;
    fork
      rx(r);
      begin
        repeat (200) @(posedge clk);
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h1, 8'h08, 32'h3);
      end
    join
    chk("aborted frame", 32'h0, {31'h0, irq});
    $display("test disable done");
    end_sim();
  end
endmodule : uarx_receiver_tb

// ### test/uarx_tx_model.sv
// Remote transmitter model driving the serial line
`timescale 1ns/1ns
module uarx_tx_model (
  // Clock and oversample tick
  input wire logic i_clk_sys,
  input wire logic i_baud_tick,
  // Serial line, idles high
  output logic o_line
);
  initial o_line = 1'h1;
  // Bits from bit 0, each held spb ticks
  task automatic send(input logic [11:0] b, input int n, input int spb);
    @(posedge i_clk_sys iff i_baud_tick);
    for (int i = 0; i < n; i++) begin
      o_line <= b[i];
      repeat (spb) @(posedge i_clk_sys iff i_baud_tick);
    end
    o_line <= 1'h1;
  endtask : send
endmodule : uarx_tx_model
